// ==== sad_pkg.sv ====
// Notes on behaviour
// - address bit 28 selects the secure or non-secure half of each window
// - bit 28 is masked before any physical location is selected
// - security permission comes from external attribution logic, an input here
// - secure address equals non-secure address with bit 28 set
// - 0x0000_0000..0x0FFF_FFFF decodes to flash, boot rom and code ram
// - 0x2000_0000..0x2FFF_FFFF decodes to three ram banks and usb buffer ram
// - 0x4000_0000..0x4FFF_FFFF decodes to ahb and apb peripheral spaces
// - secure areas may be marked non-secure callable, entered under attribution control
// - eight protection regions; each of 256 bytes or more has eight individually enabled subregions
// - a region may deny all access or allow reads only
// - no matching region or forbidden access blocks and raises memory-management fault
// - top 17 flash pages reserved, 246 KB usable
// - addresses 0x0000_0000..0x1FFF_FFFF go to the code-bus port
// - addresses 0x2000_0000..0xFFFF_FFFF go to the system-bus port
package sad_pkg;
	// ****************************************
	// address layout
	// ****************************************
	localparam int SECURE_BIT = 28;
	localparam logic [31:0] SECURE_MASK = 32'h1000_0000;
	localparam logic [31:0] CODE_PORT_LAST = 32'h1FFF_FFFF;
	localparam logic [31:0] FLASH_BASE = 32'h0000_0000;
	localparam logic [31:0] FLASH_LAST = 32'h0003_D7FF;
	localparam logic [31:0] ROM_BASE = 32'h0300_0000;
	localparam logic [31:0] ROM_LAST = 32'h0301_FFFF;
	localparam logic [31:0] CRAM_BASE = 32'h0400_0000;
	localparam logic [31:0] CRAM_LAST = 32'h0400_3FFF;
	localparam logic [31:0] RAM0_BASE = 32'h2000_0000;
	localparam logic [31:0] RAM0_LAST = 32'h2000_7FFF;
	localparam logic [31:0] RAM1_BASE = 32'h2000_8000;
	localparam logic [31:0] RAM1_LAST = 32'h2000_BFFF;
	localparam logic [31:0] RAM2_BASE = 32'h2000_C000;
	localparam logic [31:0] RAM2_LAST = 32'h2000_FFFF;
	localparam logic [31:0] USBRAM_BASE = 32'h2001_0000;
	localparam logic [31:0] USBRAM_LAST = 32'h2001_3FFF;
	localparam logic [31:0] APB_BASE = 32'h4000_0000;
	localparam logic [31:0] APB_LAST = 32'h4003_FFFF;
	localparam logic [31:0] AHBP_BASE = 32'h4008_0000;
	localparam logic [31:0] AHBP_LAST = 32'h400A_FFFF;
	// ****************************************
	// protection unit shape
	// ****************************************
	localparam int NUM_REGIONS = 8;
	localparam int NUM_SUB = 8;
	localparam int NUM_TARGETS = 9;
	typedef enum logic [1:0] {SAD_AP_NONE, SAD_AP_RO, SAD_AP_RW} sad_ap_e;
	typedef logic [3:0] sad_target_t;
	localparam sad_target_t TGT_FLASH = 4'h0;
	localparam sad_target_t TGT_ROM = 4'h1;
	localparam sad_target_t TGT_CRAM = 4'h2;
	localparam sad_target_t TGT_RAM0 = 4'h3;
	localparam sad_target_t TGT_RAM1 = 4'h4;
	localparam sad_target_t TGT_RAM2 = 4'h5;
	localparam sad_target_t TGT_USBRAM = 4'h6;
	localparam sad_target_t TGT_APB = 4'h7;
	localparam sad_target_t TGT_AHBP = 4'h8;
	localparam sad_target_t TGT_NONE = 4'hF;
endpackage : sad_pkg

// ==== sad_window_decode.sv ====
`timescale 1ns/1ps
module sad_window_decode
	import sad_pkg::*;
(
	// address in
	input wire logic [31:0] addr_i,
	// decode out
	output sad_target_t target_o,
	output logic [31:0] phys_o,
	output logic secure_o,
	output logic code_port_o
);
	logic [31:0] a;
	always_comb begin
		a = addr_i & ~SECURE_MASK;
		phys_o = a;
		secure_o = addr_i[SECURE_BIT];
		code_port_o = (addr_i <= CODE_PORT_LAST);
		target_o = TGT_NONE;
		if (a >= FLASH_BASE && a <= FLASH_LAST) begin
			target_o = TGT_FLASH;
		end else if (a >= ROM_BASE && a <= ROM_LAST) begin
			target_o = TGT_ROM;
		end else if (a >= CRAM_BASE && a <= CRAM_LAST) begin
			target_o = TGT_CRAM;
		end else if (a >= RAM0_BASE && a <= RAM0_LAST) begin
			target_o = TGT_RAM0;
		end else if (a >= RAM1_BASE && a <= RAM1_LAST) begin
			target_o = TGT_RAM1;
		end else if (a >= RAM2_BASE && a <= RAM2_LAST) begin
			target_o = TGT_RAM2;
		end else if (a >= USBRAM_BASE && a <= USBRAM_LAST) begin
			target_o = TGT_USBRAM;
		end else if (a >= APB_BASE && a <= APB_LAST) begin
			target_o = TGT_APB;
		end else if (a >= AHBP_BASE && a <= AHBP_LAST) begin
			target_o = TGT_AHBP;
		end
	end
endmodule : sad_window_decode

// ==== sad_region_check.sv ====
`timescale 1ns/1ps
module sad_region_check
	import sad_pkg::*;
(
	// access
	input wire logic [31:0] addr_i,
	input wire logic write_i,
	// region config, flattened per region
	input wire logic [NUM_REGIONS-1:0] en_i,
	input wire logic [NUM_REGIONS*32-1:0] base_i,
	input wire logic [NUM_REGIONS*5-1:0] size_log2_i,
	input wire logic [NUM_REGIONS*NUM_SUB-1:0] sub_dis_i,
	input wire logic [NUM_REGIONS*2-1:0] ap_i,
	// verdict
	output logic allow_o
);
	logic [NUM_REGIONS-1:0] hit;
	logic [NUM_REGIONS-1:0] ok;
	genvar g;
	generate
		for (g = 0; g < NUM_REGIONS; g++) begin : g_reg
			logic [31:0] base;
			logic [4:0] sz;
			logic [31:0] mask;
			logic [31:0] off;
			logic [2:0] sub;
			logic [1:0] ap;
			always_comb begin
				base = base_i[g*32 +: 32];
				sz = size_log2_i[g*5 +: 5];
				ap = ap_i[g*2 +: 2];
				// size is 2^(sz+1) bytes; subregion is the top 3 offset bits
				mask = ~((32'h0000_0002 << sz) - 32'h0000_0001);
				off = addr_i - (base & mask);
				// eight subregions: the offset bits just below the region size
				sub = 3'(off >> (sz - 5'h02));
				hit[g] = en_i[g] && ((addr_i & mask) == (base & mask))
					&& (sz >= 5'h07 ? !sub_dis_i[g*NUM_SUB + int'(sub)] : 1'b1);
				ok[g] = (ap == SAD_AP_RW) || (ap == SAD_AP_RO && !write_i);
			end
		end
	endgenerate
	// highest-numbered matching region decides, as on the usual protection units
	always_comb begin
		allow_o = 1'b0;
		for (int i = 0; i < NUM_REGIONS; i++) begin
			if (hit[i]) begin
				allow_o = ok[i];
			end
		end
	end
endmodule : sad_region_check

// ==== sad_decoder.sv ====
`timescale 1ns/1ps
module sad_decoder
	import sad_pkg::*;
(
	// clock and reset
	input wire logic CLOCK_I,
	input wire logic RESET_I,
	// access request
	input wire logic REQ_VALID_I,
	input wire logic [31:0] REQ_ADDR_I,
	input wire logic REQ_WRITE_I,
	// attribution verdict from separate logic
	input wire logic ATTR_ALLOW_I,
	input wire logic ATTR_NSC_I,
	// protection unit config
	input wire logic PROT_ENABLE_I,
	input wire logic [NUM_REGIONS-1:0] REGION_EN_I,
	input wire logic [NUM_REGIONS*32-1:0] REGION_BASE_I,
	input wire logic [NUM_REGIONS*5-1:0] REGION_SIZE_I,
	input wire logic [NUM_REGIONS*NUM_SUB-1:0] REGION_SUB_DIS_I,
	input wire logic [NUM_REGIONS*2-1:0] REGION_AP_I,
	// routed access
	output logic CODE_VALID_O,
	output logic SYS_VALID_O,
	output logic [31:0] PHYS_ADDR_O,
	output logic [NUM_TARGETS-1:0] SEL_O,
	output logic SECURE_O,
	output logic NSC_O,
	output logic WRITE_O,
	// fault answers
	output logic BUS_ERROR_O,
	output logic MEM_FAULT_O,
	output logic ATTR_FAULT_O
);
	// ****************************************
	// decode and check
	// ****************************************
	sad_target_t tgt;
	logic [31:0] phys;
	logic sec;
	logic code_port;
	logic prot_allow;
	sad_window_decode u_dec (
		.addr_i(REQ_ADDR_I),
		.target_o(tgt),
		.phys_o(phys),
		.secure_o(sec),
		.code_port_o(code_port)
	);
	sad_region_check u_chk (
		.addr_i(REQ_ADDR_I),
		.write_i(REQ_WRITE_I),
		.en_i(REGION_EN_I),
		.base_i(REGION_BASE_I),
		.size_log2_i(REGION_SIZE_I),
		.sub_dis_i(REGION_SUB_DIS_I),
		.ap_i(REGION_AP_I),
		.allow_o(prot_allow)
	);
	// ****************************************
	// registered outcome
	// ****************************************
	logic next_code_valid, next_sys_valid, next_secure, next_nsc, next_write;
	logic next_bus_error, next_mem_fault, next_attr_fault;
	logic [31:0] next_phys;
	logic [NUM_TARGETS-1:0] next_sel;
	always_comb begin
		next_code_valid = 1'b0;
		next_sys_valid = 1'b0;
		next_sel = '0;
		next_phys = PHYS_ADDR_O;
		next_secure = SECURE_O;
		next_nsc = NSC_O;
		next_write = WRITE_O;
		next_bus_error = 1'b0;
		next_mem_fault = 1'b0;
		next_attr_fault = 1'b0;
		if (REQ_VALID_I) begin
			next_phys = phys;
			next_secure = sec;
			next_nsc = sec && ATTR_NSC_I;
			next_write = REQ_WRITE_I;
			// protection disabled means all accesses pass the region check
			if (PROT_ENABLE_I && !prot_allow) begin
				next_mem_fault = 1'b1;
			end else if (!ATTR_ALLOW_I) begin
				next_attr_fault = 1'b1;
			end else if (tgt == TGT_NONE) begin
				next_bus_error = 1'b1;
			end else begin
				next_sel[tgt] = 1'b1;
				next_code_valid = code_port;
				next_sys_valid = !code_port;
			end
		end
	end
	always_ff @(posedge CLOCK_I) begin
		if (RESET_I) begin
			CODE_VALID_O <= 1'b0;
			SYS_VALID_O <= 1'b0;
			PHYS_ADDR_O <= '0;
			SEL_O <= '0;
			SECURE_O <= 1'b0;
			NSC_O <= 1'b0;
			WRITE_O <= 1'b0;
			BUS_ERROR_O <= 1'b0;
			MEM_FAULT_O <= 1'b0;
			ATTR_FAULT_O <= 1'b0;
		end else begin
			CODE_VALID_O <= next_code_valid;
			SYS_VALID_O <= next_sys_valid;
			PHYS_ADDR_O <= next_phys;
			SEL_O <= next_sel;
			SECURE_O <= next_secure;
			NSC_O <= next_nsc;
			WRITE_O <= next_write;
			BUS_ERROR_O <= next_bus_error;
			MEM_FAULT_O <= next_mem_fault;
			ATTR_FAULT_O <= next_attr_fault;
		end
	end
endmodule : sad_decoder

// ==== sad_decoder_props.sv ====
`timescale 1ns/1ps
module sad_decoder_props
	import sad_pkg::*;
(
	// clock and reset
	input wire logic CLOCK_I,
	input wire logic RESET_I,
	// request side
	input wire logic REQ_VALID_I,
	input wire logic [31:0] REQ_ADDR_I,
	input wire logic REQ_WRITE_I,
	input wire logic ATTR_ALLOW_I,
	input wire logic ATTR_NSC_I,
	input wire logic PROT_ENABLE_I,
	input wire logic [NUM_REGIONS*2-1:0] REGION_AP_I,
	// answer side
	input wire logic CODE_VALID_O,
	input wire logic SYS_VALID_O,
	input wire logic [31:0] PHYS_ADDR_O,
	input wire logic [NUM_TARGETS-1:0] SEL_O,
	input wire logic SECURE_O,
	input wire logic NSC_O,
	input wire logic BUS_ERROR_O,
	input wire logic MEM_FAULT_O,
	input wire logic ATTR_FAULT_O
);
	// ****
	// properties
	// ****
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (RESET_I);
	property p_ans; REQ_VALID_I |=> $onehot({CODE_VALID_O, SYS_VALID_O, BUS_ERROR_O, MEM_FAULT_O, ATTR_FAULT_O}); endproperty
	a_ans: assert property (p_ans) else $error("not one answer");
	property p_phys; REQ_VALID_I |=> PHYS_ADDR_O == ($past(REQ_ADDR_I) & ~SECURE_MASK); endproperty
	a_phys: assert property (p_phys) else $error("bad physical address");
	property p_sec; REQ_VALID_I |=> SECURE_O == $past(REQ_ADDR_I[SECURE_BIT]); endproperty
	a_sec: assert property (p_sec) else $error("bad secure flag");
	property p_nsc; REQ_VALID_I |=> NSC_O == $past(REQ_ADDR_I[SECURE_BIT] && ATTR_NSC_I); endproperty
	a_nsc: assert property (p_nsc) else $error("bad callable flag");
	property p_code; REQ_VALID_I && REQ_ADDR_I > CODE_PORT_LAST |=> !CODE_VALID_O; endproperty
	a_code: assert property (p_code) else $error("data address on code port");
	property p_sys; REQ_VALID_I && REQ_ADDR_I <= CODE_PORT_LAST |=> !SYS_VALID_O; endproperty
	a_sys: assert property (p_sys) else $error("code address on system port");
	property p_attr; REQ_VALID_I && !PROT_ENABLE_I && !ATTR_ALLOW_I |=> ATTR_FAULT_O; endproperty
	a_attr: assert property (p_attr) else $error("attribution refusal lost");
	property p_ro; REQ_VALID_I && PROT_ENABLE_I && REQ_WRITE_I && REGION_AP_I == 16'h4000 |=> MEM_FAULT_O; endproperty
	a_ro: assert property (p_ro) else $error("write to read-only passed");
	property p_sel; CODE_VALID_O || SYS_VALID_O |-> $onehot(SEL_O); endproperty
	a_sel: assert property (p_sel) else $error("select not one-hot");
endmodule : sad_decoder_props
bind sad_decoder sad_decoder_props i_sad_decoder_props (.*);

// ==== sad_master_model.sv ====
`timescale 1ns/1ps
module sad_master_model (
	// clock
	input wire logic clk_i,
	// request
	output logic valid_o,
	output logic [31:0] addr_o,
	output logic write_o
);
	initial {valid_o, addr_o, write_o} = '0;
	task automatic access(input logic [31:0] a, input logic s, input logic w);
		@(posedge clk_i);
		valid_o <= 1'h1;
		addr_o <= a | {3'h0, s, 28'h000_0000};
		write_o <= w;
	endtask : access
	// a released bus must not look like the last request
	task automatic idle();
		@(posedge clk_i);
		valid_o <= 1'h0;
		addr_o <= ~addr_o;
		write_o <= ~write_o;
	endtask : idle
endmodule : sad_master_model

// ==== sad_decoder_tb_top.sv ====
`timescale 1ns/1ps
module sad_decoder_tb_top;
	import sad_pkg::*;
	logic clk = 0, rst = 1, valid, wr, allow = 0, nsc = 0, prot = 0, pv = 0, pn, pw;
	logic [7:0] ren = 0;
	logic [63:0] sdis = 0;
	logic [15:0] ap = 0;
	logic [31:0] addr, phys, pa;
	logic code_v, sys_v, sec, nsc_q, wr_q, berr, mflt, aflt;
	logic [8:0] sel;
	int err_total = 0, check_count = 0, seed = 38, pk, ps, r;
	logic [31:0] lo[9] = '{FLASH_BASE, ROM_BASE, CRAM_BASE, RAM0_BASE, RAM1_BASE, RAM2_BASE, USBRAM_BASE, APB_BASE, AHBP_BASE};
	logic [31:0] hi[9] = '{FLASH_LAST, ROM_LAST, CRAM_LAST, RAM0_LAST, RAM1_LAST, RAM2_LAST, USBRAM_LAST, APB_LAST, AHBP_LAST};
	// window edges and gaps, where off-by-one slips show
	logic [31:0] pool[16] = '{FLASH_BASE, FLASH_LAST, FLASH_LAST + 1, ROM_LAST, CRAM_BASE, CRAM_LAST + 1, RAM0_LAST, RAM1_BASE,
		RAM2_LAST, USBRAM_LAST, USBRAM_LAST + 1, APB_LAST, AHBP_BASE, AHBP_LAST + 1, 32'h6000_0000, 32'hEFFF_FFFF};
	always #25 clk = ~clk;
	sad_master_model i_sad_master_model (.clk_i(clk), .valid_o(valid), .addr_o(addr), .write_o(wr));
	sad_decoder i_sad_decoder (.CLOCK_I(clk), .RESET_I(rst), .REQ_VALID_I(valid), .REQ_ADDR_I(addr), .REQ_WRITE_I(wr),
		.ATTR_ALLOW_I(allow), .ATTR_NSC_I(nsc), .PROT_ENABLE_I(prot), .REGION_EN_I(ren), .REGION_BASE_I('0),
		.REGION_SIZE_I(40'hF8_0000_0000), .REGION_SUB_DIS_I(sdis), .REGION_AP_I(ap), .CODE_VALID_O(code_v),
		.SYS_VALID_O(sys_v), .PHYS_ADDR_O(phys), .SEL_O(sel), .SECURE_O(sec), .NSC_O(nsc_q), .WRITE_O(wr_q),
		.BUS_ERROR_O(berr), .MEM_FAULT_O(mflt), .ATTR_FAULT_O(aflt));
	task automatic cmp_bit(input logic g, input logic e);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %0t flag %b expected %b", $time, g, e);
		end
	endtask : cmp_bit
	task automatic cmp_vec(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %0t value %h expected %h", $time, g, e);
		end
	endtask : cmp_vec
	task automatic give_verdict();
		if (err_total == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict
	// ****
	// reference: outputs read before this edge's updates land
	// ****
	always @(posedge clk) begin
		if (pv) begin
			cmp_bit(code_v, pk == 0);
			cmp_bit(sys_v, pk == 1);
			cmp_bit(berr, pk == 2);
			cmp_bit(mflt, pk == 3);
			cmp_bit(aflt, pk == 4);
			cmp_vec(32'(sel), pk < 2 ? 32'h0000_0001 << ps : 32'h0000_0000);
			cmp_vec(phys, pa & ~SECURE_MASK);
			cmp_bit(sec, pa[28]);
			cmp_bit(nsc_q, pn);
			cmp_bit(wr_q, pw);
		end
		pv = valid && !rst;
		pa = addr;
		pn = addr[28] && nsc;
		pw = wr;
		ps = 9;
		for (int i = 0; i < 9; i++)
			if ((addr & ~SECURE_MASK) >= lo[i] && (addr & ~SECURE_MASK) <= hi[i]) ps = i;
		if (prot && !(ren[7] && !sdis[56 + addr[31:29]] && (ap[15:14] == 2 || ap[15:14] == 1 && !wr))) pk = 3;
		else if (!allow) pk = 4;
		else if (ps == 9) pk = 2;
		else pk = addr <= CODE_PORT_LAST ? 0 : 1;
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 0;
		for (int n = 0; n < 800; n++) begin
			r = $random(seed);
			prot <= n >= 400;
			ren <= 8'($random(seed));
			sdis <= {8'($random(seed) & $random(seed)), 56'h00_0000_0000_0000};
			ap <= {r[13:12], 14'h0000};
			allow <= r[3:2] != 0;
			nsc <= r[4];
			if (r[6:5] == 3)
				i_sad_master_model.idle();
			else
				i_sad_master_model.access(pool[r[11:8]], r[7], r[1]);
		end
		i_sad_master_model.idle();
		repeat (3) @(negedge clk);
		give_verdict();
	end
	initial begin
		#100_000;
		err_total++;
		give_verdict();
	end
endmodule : sad_decoder_tb_top
